// file: hw/bbch_top.sv
// Added by the designer: the strobed register port and the register offsets.
module bbch_top (
	// clock and reset
	input  wire logic         clk_in,
	input  wire logic         nrst_in,
	// register port
	input  wire logic [7:0]   addr_in,
	input  wire logic [15:0]  wdata_in,
	input  wire logic         wr_in,
	input  wire logic         rd_in,
	output logic      [15:0]  rdata_out,
	// converter results, one channel per strobe
	input  wire logic         conv_in,
	input  wire logic [3:0]   conv_ch_in,
	input  wire logic signed [15:0] main_in,
	input  wire logic signed [15:0] aux_in,
	input  wire logic         bb_conv_in,
	input  wire logic signed [15:0] bb_main_in,
	input  wire logic signed [15:0] bb_aux_in,
	// pins and events
	output logic              sink_pos_out,
	output logic              sink_neg_out,
	output logic      [15:0]  balancing_switch_out,
	output logic              balancing_complete_flag_out,
	output logic              irq_out
);
	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [15:0] bus_bar_position;
	logic [1:0]  open_wire_sink_select;
	logic [3:0]  shared_channel_location;
	logic [3:0]  ctrl;
	logic signed [15:0] ov_th, uv_th, cb_th;
	logic [15:0] cb_req, cb_time, tol;
	logic [4:0]  status, mask;
	logic [15:0] ov_flags, uv_flags, cmp_flags;
	logic signed [15:0] res [16];
	logic signed [15:0] aux_res [16];
	logic signed [15:0] bb_main;
	logic [15:0] sw_on;
	logic [15:0] cb_ran, next_cb_ran;   // switch already ran for the standing request
	logic [15:0] timer [16];
	logic [15:0] tick_cnt;
	logic        tick;

	logic [15:0] next_bus_bar_position, next_cb_req, next_cb_time, next_tol;
	logic [1:0]  next_sink;
	logic [3:0]  next_shared, next_ctrl;
	logic signed [15:0] next_ov_th, next_uv_th, next_cb_th;
	logic [4:0]  next_status, next_mask;
	logic [15:0] next_ov_flags, next_uv_flags, next_cmp_flags, next_rdata;
	logic signed [15:0] next_res, clamped;
	logic [15:0] next_sw_on, next_tick_cnt;
	logic [15:0] next_timer [16];
	logic [4:0]  ev;
	logic        all_done;

	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------
	// clamp a conversion to its channel's reportable range
	function automatic logic signed [15:0] bbch_clamp(input logic signed [15:0] v, input logic [3:0] ch);
		logic signed [15:0] lo;
		lo = (ch == 4'h0) ? bbch_pkg::V0_MIN : bbch_pkg::V_MIN;
		if (v < lo) begin
			return lo;
		end
		if (v > bbch_pkg::V_MAX) begin
			return bbch_pkg::V_MAX;
		end
		return v;
	endfunction : bbch_clamp

	// summed value of a bar channel and the cell above it
	function automatic logic signed [15:0] bbch_pair(input logic signed [15:0] a, input logic signed [15:0] b);
		return 16'(a + b);
	endfunction : bbch_pair

	// ---------------------------------------------------------------
	// comparators: per-channel and dedicated pair
	// ---------------------------------------------------------------
	logic        cmp_go, cmp_valid, cmp_fail, bb_valid, bb_fail;
	logic signed [15:0] cmp_main, cmp_aux, cur_main, cur_aux;
	logic [3:0]  cmp_ch, cmp_ch_q;
	logic [3:0]  up;

	// bar channels 0 to 14 compare as bar plus cell above; shared channel main against its aux plus pair main
	always_comb begin
		up       = 4'(conv_ch_in + 4'h1);
		cur_main = bbch_clamp(main_in, conv_ch_in);
		cur_aux  = bbch_clamp(aux_in, conv_ch_in);
		cmp_go   = conv_in && ctrl[bbch_pkg::C_DIAG_EN];
		cmp_ch   = conv_ch_in;
		cmp_main = cur_main;
		cmp_aux  = cur_aux;
		if (bus_bar_position[conv_ch_in] && conv_ch_in != 4'hF) begin
			cmp_main = bbch_pair(cur_main, res[up]);
			cmp_aux  = bbch_pair(cur_aux, aux_res[up]);
		end else if (conv_ch_in == shared_channel_location) begin
			cmp_main = cur_main;
			cmp_aux  = bbch_pair(cur_aux, bb_main);
		end
	end

	bbch_cmp u_cmp (
		.clk_in    (clk_in),
		.nrst_in   (nrst_in),
		.go_in     (cmp_go),
		.main_in   (cmp_main),
		.aux_in    (cmp_aux),
		.tol_in    (tol),
		.valid_out (cmp_valid),
		.fail_out  (cmp_fail)
	);

	bbch_cmp u_bbcmp (
		.clk_in    (clk_in),
		.nrst_in   (nrst_in),
		.go_in     (bb_conv_in && ctrl[bbch_pkg::C_DIAG_EN]),
		.main_in   (bb_main_in),
		.aux_in    (bb_aux_in),
		.tol_in    (tol),
		.valid_out (bb_valid),
		.fail_out  (bb_fail)
	);

	// ---------------------------------------------------------------
	// next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		next_bus_bar_position = bus_bar_position;
		next_sink     = open_wire_sink_select;
		next_shared   = shared_channel_location;
		next_ctrl     = ctrl;
		next_ov_th    = ov_th;
		next_uv_th    = uv_th;
		next_cb_th    = cb_th;
		next_cb_req   = cb_req;
		next_cb_time  = cb_time;
		next_tol      = tol;
		next_mask     = mask;
		next_ov_flags = ov_flags;
		next_uv_flags = uv_flags;
		next_cmp_flags = cmp_flags;
		next_res      = bbch_clamp(main_in, conv_ch_in);
		clamped       = next_res;
		next_sw_on    = sw_on;
		next_cb_ran   = cb_ran;
		next_timer    = timer;
		ev            = '0;
		next_tick_cnt = (tick_cnt == 16'(bbch_pkg::TICK_CYC - 1)) ? '0 : 16'(tick_cnt + 16'h1);
		// register writes
		if (wr_in) begin
			unique case (addr_in)
				bbch_pkg::A_POS_LOW:  next_bus_bar_position[7:0]  = wdata_in[7:0];
				bbch_pkg::A_POS_HIGH: next_bus_bar_position[15:8] = wdata_in[7:0];
				bbch_pkg::A_DIAG3:    next_sink   = wdata_in[1:0];
				bbch_pkg::A_SHARED:   next_shared = wdata_in[3:0];
				bbch_pkg::A_CTRL:     next_ctrl   = wdata_in[3:0];
				bbch_pkg::A_OV_TH:    next_ov_th  = wdata_in;
				bbch_pkg::A_UV_TH:    next_uv_th  = wdata_in;
				bbch_pkg::A_CB_TH:    next_cb_th  = wdata_in;
				bbch_pkg::A_CB_EN:    next_cb_req = wdata_in;
				bbch_pkg::A_CB_TIME:  next_cb_time = wdata_in;
				bbch_pkg::A_CMP_TOL:  next_tol    = wdata_in;
				bbch_pkg::A_MASK:     next_mask   = wdata_in[4:0];
				default: ;
			endcase
		end
		// balancing: one run per request, stop on timer or voltage
		// without the ran mark a stopped switch would re-arm on the next cycle
		if (wr_in && addr_in == bbch_pkg::A_CB_EN) begin
			next_cb_ran = '0;
		end
		for (int i = 0; i < 16; i++) begin
			if (ctrl[bbch_pkg::C_CB_GO] && cb_req[i] && !sw_on[i] && !cb_ran[i]) begin
				next_sw_on[i]  = 1'b1;
				next_cb_ran[i] = 1'b1;
				next_timer[i]  = cb_time;
			end else if (sw_on[i]) begin
				if (tick) begin
					next_timer[i] = 16'(timer[i] - 16'h1);
				end
				if (timer[i] == '0 || (tick && timer[i] == 16'h1)) begin
					next_sw_on[i] = 1'b0;
				end
			end
			if (!ctrl[bbch_pkg::C_CB_GO]) begin
				next_sw_on[i]  = 1'b0;
				next_cb_ran[i] = 1'b0;
				next_timer[i]  = '0;
			end
		end
		// conversion results: voltage checks
		if (conv_in) begin
			if (ctrl[bbch_pkg::C_VCB_EN] && sw_on[conv_ch_in] && !bus_bar_position[conv_ch_in]
			    && clamped <= cb_th) begin
				next_sw_on[conv_ch_in] = 1'b0;
				next_timer[conv_ch_in] = '0;
			end
			if (ctrl[bbch_pkg::C_OVER_UNDER_VOLTAGE_PROTECTOR_EN] && !bus_bar_position[conv_ch_in]) begin
				next_ov_flags[conv_ch_in] = clamped > ov_th;
				next_uv_flags[conv_ch_in] = clamped < uv_th;
				ev[bbch_pkg::S_OV] = clamped > ov_th;
				ev[bbch_pkg::S_UV] = clamped < uv_th;
			end
		end
		if (cmp_valid) begin
			next_cmp_flags[cmp_ch_q] = cmp_fail;
			ev[bbch_pkg::S_CMP] = cmp_fail;
		end
		ev[bbch_pkg::S_BBCMP] = bb_valid && bb_fail;
		ev[bbch_pkg::S_CBDONE] = all_done && !balancing_complete_flag_out;
		// write-one-to-clear, a same-cycle event wins
		next_status = status;
		if (wr_in && addr_in == bbch_pkg::A_STATUS) begin
			next_status = status & ~wdata_in[4:0];
		end
		next_status = next_status | ev;
		// read mux
		next_rdata = '0;
		if (rd_in) begin
			unique case (addr_in)
				bbch_pkg::A_POS_LOW:   next_rdata = {8'h00, bus_bar_position[7:0]};
				bbch_pkg::A_POS_HIGH:  next_rdata = {8'h00, bus_bar_position[15:8]};
				bbch_pkg::A_DIAG3:     next_rdata = {14'h0000, open_wire_sink_select};
				bbch_pkg::A_SHARED:    next_rdata = {12'h000, shared_channel_location};
				bbch_pkg::A_CTRL:      next_rdata = {12'h000, ctrl};
				bbch_pkg::A_OV_TH:     next_rdata = ov_th;
				bbch_pkg::A_UV_TH:     next_rdata = uv_th;
				bbch_pkg::A_CB_TH:     next_rdata = cb_th;
				bbch_pkg::A_CB_EN:     next_rdata = cb_req;
				bbch_pkg::A_CB_TIME:   next_rdata = cb_time;
				bbch_pkg::A_CMP_TOL:   next_rdata = tol;
				bbch_pkg::A_STATUS:    next_rdata = {11'h000, status};
				bbch_pkg::A_MASK:      next_rdata = {11'h000, mask};
				bbch_pkg::A_SW_STATE:  next_rdata = sw_on;
				bbch_pkg::A_OV_FLAGS:  next_rdata = ov_flags;
				bbch_pkg::A_UV_FLAGS:  next_rdata = uv_flags;
				bbch_pkg::A_CMP_FLAGS: next_rdata = cmp_flags;
				bbch_pkg::A_BB_MAIN:   next_rdata = bb_main;
				default: begin
					if (addr_in[7:4] == bbch_pkg::A_RES_BASE[7:4]) begin
						next_rdata = res[addr_in[3:0]];
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// state registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			bus_bar_position        <= '0;
			open_wire_sink_select   <= '0;
			shared_channel_location <= '0;
			ctrl      <= '0;
			ov_th     <= bbch_pkg::V_MAX;
			uv_th     <= bbch_pkg::V_MIN;
			cb_th     <= bbch_pkg::V_MIN;
			cb_req    <= '0;
			cb_time   <= '0;
			tol       <= '0;
			status    <= '0;
			mask      <= '0;
			ov_flags  <= '0;
			uv_flags  <= '0;
			cmp_flags <= '0;
			sw_on     <= '0;
			cb_ran    <= '0;
			tick_cnt  <= '0;
			bb_main   <= '0;
			cmp_ch_q  <= '0;
			rdata_out <= '0;
			balancing_complete_flag_out <= 1'b0;
			for (int i = 0; i < 16; i++) begin
				timer[i]   <= '0;
				res[i]     <= '0;
				aux_res[i] <= '0;
			end
		end else begin
			bus_bar_position        <= next_bus_bar_position;
			open_wire_sink_select   <= next_sink;
			shared_channel_location <= next_shared;
			ctrl      <= next_ctrl;
			ov_th     <= next_ov_th;
			uv_th     <= next_uv_th;
			cb_th     <= next_cb_th;
			cb_req    <= next_cb_req;
			cb_time   <= next_cb_time;
			tol       <= next_tol;
			status    <= next_status;
			mask      <= next_mask;
			ov_flags  <= next_ov_flags;
			uv_flags  <= next_uv_flags;
			cmp_flags <= next_cmp_flags;
			sw_on     <= next_sw_on;
			cb_ran    <= next_cb_ran;
			tick_cnt  <= next_tick_cnt;
			timer     <= next_timer;
			cmp_ch_q  <= cmp_ch;
			rdata_out <= next_rdata;
			balancing_complete_flag_out <= all_done;
			if (bb_conv_in) begin
				bb_main <= bb_main_in;
			end
			if (conv_in) begin
				res[conv_ch_in]     <= next_res;
				aux_res[conv_ch_in] <= bbch_clamp(aux_in, conv_ch_in);
			end
		end
	end

	// divider tick and completion: flag waits for every switch incl. bar ones
	assign tick     = (tick_cnt == 16'(bbch_pkg::TICK_CYC - 1));
	// done only once every requested switch has run and is off again
	assign all_done = ctrl[bbch_pkg::C_CB_GO] && (cb_req != '0) && (sw_on == '0)
	                  && ((cb_req & ~cb_ran) == '0);

	// outputs: sinks only on the all-ones code
	assign sink_pos_out         = (open_wire_sink_select == bbch_pkg::SNK_ON);
	assign sink_neg_out         = (open_wire_sink_select == bbch_pkg::SNK_ON);
	assign balancing_switch_out = sw_on;
	assign irq_out              = |(status & mask);

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	sink_code_a: assert property (sink_pos_out == (open_wire_sink_select == bbch_pkg::SNK_ON))
		else $error("sink state disagrees with select code");
	sink_pair_a: assert property (sink_pos_out == sink_neg_out)
		else $error("bar sinks not on together");
	res_range_a: assert property (conv_in |=> res[$past(conv_ch_in)] >= bbch_pkg::V_MIN
		&& res[$past(conv_ch_in)] <= bbch_pkg::V_MAX)
		else $error("result outside reportable range");
	over_under_voltage_protector_skip_a: assert property (conv_in && bus_bar_position[conv_ch_in] |=> $stable(ov_flags) && $stable(uv_flags))
		else $error("bar channel touched over/under flags");
	vcb_skip_a: assert property (conv_in && bus_bar_position[conv_ch_in] && sw_on[conv_ch_in]
		&& timer[conv_ch_in] != 16'h0 && !(tick && timer[conv_ch_in] == 16'h1)
		&& ctrl[bbch_pkg::C_CB_GO] |=> sw_on[$past(conv_ch_in)])
		else $error("bar switch stopped by voltage check");
	vcb_stop_a: assert property (conv_in && ctrl[bbch_pkg::C_VCB_EN] && ctrl[bbch_pkg::C_CB_GO]
		&& sw_on[conv_ch_in] && !bus_bar_position[conv_ch_in]
		&& bbch_clamp(main_in, conv_ch_in) <= cb_th |=> !sw_on[$past(conv_ch_in)])
		else $error("cell switch not stopped at threshold");
	bbcmp_lat_a: assert property (bb_conv_in && ctrl[bbch_pkg::C_DIAG_EN]
		&& (bb_main_in - bb_aux_in > 17'sd0 ? bb_main_in - bb_aux_in : bb_aux_in - bb_main_in)
		> $signed({1'b0, tol}) |-> ##2 status[bbch_pkg::S_BBCMP])
		else $error("pair mismatch not flagged");
	irq_lvl_a: assert property (irq_out == |(status & mask))
		else $error("interrupt level wrong");
endmodule : bbch_top

// file: hw/bbch_pkg.sv
package bbch_pkg;
	// ---------------------------------------------------------------
	// geometry
	// ---------------------------------------------------------------
	localparam int unsigned NCH    = 16;          // cell sense channels
	localparam int unsigned RW     = 16;          // result width, signed
	localparam int unsigned AW     = 8;           // register address width

	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] A_POS_LOW   = 8'h00;   // bus_bar_position_low
	localparam logic [7:0] A_POS_HIGH  = 8'h01;   // bus_bar_position_high
	localparam logic [7:0] A_DIAG3     = 8'h02;   // diagnostic_compare_control_three
	localparam logic [7:0] A_SHARED    = 8'h03;   // shared_channel_location
	localparam logic [7:0] A_CTRL      = 8'h04;   // protector / balance enables
	localparam logic [7:0] A_OV_TH     = 8'h05;
	localparam logic [7:0] A_UV_TH     = 8'h06;
	localparam logic [7:0] A_CB_TH     = 8'h07;   // balance stop voltage
	localparam logic [7:0] A_CB_EN     = 8'h08;   // balancing switch requests
	localparam logic [7:0] A_CB_TIME   = 8'h09;   // timer setting, ticks
	localparam logic [7:0] A_CMP_TOL   = 8'h0A;   // main vs aux tolerance
	localparam logic [7:0] A_STATUS    = 8'h0B;   // sticky events, w1c
	localparam logic [7:0] A_MASK      = 8'h0C;
	localparam logic [7:0] A_SW_STATE  = 8'h0D;   // balancing switches now on
	localparam logic [7:0] A_OV_FLAGS  = 8'h0E;
	localparam logic [7:0] A_UV_FLAGS  = 8'h0F;
	localparam logic [7:0] A_CMP_FLAGS = 8'h10;
	localparam logic [7:0] A_BB_MAIN   = 8'h11;   // dedicated pair, main result
	localparam logic [7:0] A_RES_BASE  = 8'h20;   // channel_voltage_result 0..15

	// ---------------------------------------------------------------
	// fields and codes
	// ---------------------------------------------------------------
	localparam logic [1:0] SNK_ON      = 2'h3;    // sink select all-ones
	localparam int unsigned C_OVER_UNDER_VOLTAGE_PROTECTOR_EN  = 0;
	localparam int unsigned C_CB_GO    = 1;
	localparam int unsigned C_VCB_EN   = 2;
	localparam int unsigned C_DIAG_EN  = 3;
	localparam int unsigned S_OV       = 0;
	localparam int unsigned S_UV       = 1;
	localparam int unsigned S_CMP      = 2;
	localparam int unsigned S_BBCMP    = 3;
	localparam int unsigned S_CBDONE   = 4;
	localparam int unsigned NSTAT      = 5;

	// signed result range -2 V .. 5 V at 1 mV per lsb
	localparam logic signed [15:0] V_MIN  = -16'sd2000;
	localparam logic signed [15:0] V_MAX  = 16'sd5000;
	localparam logic signed [15:0] V0_MIN = 16'sd0;   // lowest channel

	// balancing timer tick: 1 ms at 40 MHz
	localparam int unsigned CLK_HZ   = 40_000_000;
	localparam int unsigned TICK_US  = 1000;
	localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
endpackage : bbch_pkg

// file: hw/bbch_cmp.sv
// main-versus-aux compare with tolerance, one stage of flops
module bbch_cmp (
	// clock and reset
	input  wire logic                clk_in,
	input  wire logic                nrst_in,
	// operands
	input  wire logic                go_in,
	input  wire logic signed [15:0]  main_in,
	input  wire logic signed [15:0]  aux_in,
	input  wire logic        [15:0]  tol_in,
	// result
	output logic                     valid_out,
	output logic                     fail_out
);
	logic next_valid;
	logic next_fail;
	logic signed [16:0] diff;

	// absolute difference against tolerance
	always_comb begin
		diff       = 17'(main_in) - 17'(aux_in);
		if (diff < 0) begin
			diff = -diff;
		end
		next_valid = go_in;
		next_fail  = go_in && (diff > $signed({1'b0, tol_in}));
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			valid_out <= 1'b0;
			fail_out  <= 1'b0;
		end else begin
			valid_out <= next_valid;
			fail_out  <= next_fail;
		end
	end
endmodule : bbch_cmp

// file: bench/test_bbch_top.sv
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module test_bbch_top;
	timeunit 1ns;
	timeprecision 100ps;
	// ---------------------------------------------------------------
	// stimulus signals
	// ---------------------------------------------------------------
	logic               clk_in = 1'b0;
	logic               nrst_in = 1'b0;
	logic        [7:0]  addr_in = 8'h00;
	logic        [15:0] wdata_in = 16'h0000;
	logic               wr_in = 1'b0;
	logic               rd_in = 1'b0;
	logic        [15:0] rdata_out;
	logic               conv_in = 1'b0;
	logic        [3:0]  conv_ch_in = 4'h0;
	logic signed [15:0] main_in = 16'h0000;
	logic signed [15:0] aux_in = 16'h0000;
	logic               bb_conv_in = 1'b0;
	logic signed [15:0] bb_main_in = 16'h0000;
	logic signed [15:0] bb_aux_in = 16'h0000;
	logic               sink_pos_out;
	logic               sink_neg_out;
	logic        [15:0] balancing_switch_out;
	logic               balancing_complete_flag_out;
	logic               irq_out;
	int                 mismatches = 0;
	int                 compares = 0;
	logic        [15:0] exp_q[$];
	logic               rd_seen = 1'b0;
	logic        [31:0] seed = 32'h0000_6356;
	logic        [15:0] v;
	logic        [15:0] exp_v;

	bbch_top dut_u (
		.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .conv_in(conv_in), .conv_ch_in(conv_ch_in), .main_in(main_in),
		.aux_in(aux_in), .bb_conv_in(bb_conv_in), .bb_main_in(bb_main_in), .bb_aux_in(bb_aux_in),
		.sink_pos_out(sink_pos_out), .sink_neg_out(sink_neg_out), .balancing_switch_out(balancing_switch_out),
		.balancing_complete_flag_out(balancing_complete_flag_out), .irq_out(irq_out)
	);

	// 40 MHz clock
	always #12.5 clk_in = ~clk_in;

	// ---------------------------------------------------------------
	// bus and conversion tasks
	// ---------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	task automatic do_reset();
		@(posedge clk_in);
		nrst_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		nrst_in <= 1'b1;
	endtask : do_reset

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in    <= 1'b0;
	endtask : wr

	// the expected read value is noted before the strobe goes out
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_in);
		exp_q.push_back(e);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in   <= 1'b0;
	endtask : rd

	// one conversion, then time for the result and compare stages to land
	task automatic conv(input logic [3:0] ch, input logic [15:0] m, input logic [15:0] x);
		@(posedge clk_in);
		conv_ch_in <= ch;
		main_in    <= m;
		aux_in     <= x;
		conv_in    <= 1'b1;
		@(posedge clk_in);
		conv_in    <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask : conv

	task automatic bbconv(input logic [15:0] m, input logic [15:0] x);
		@(posedge clk_in);
		bb_main_in <= m;
		bb_aux_in  <= x;
		bb_conv_in <= 1'b1;
		@(posedge clk_in);
		bb_conv_in <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask : bbconv

	task automatic wrap_up();
		if (mismatches == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	// ---------------------------------------------------------------
	// read data watcher: data stands only in the cycle after the strobe
	// ---------------------------------------------------------------
	always @(posedge clk_in) begin
		if (rd_seen) begin
			if (exp_q.size() == 0) begin
				mismatches++;
				$display("ERROR %0t: read data without a noted value", $time);
			end else begin
				// pop once: the macro names its operands twice
				exp_v = exp_q.pop_front();
				`CHK(rdata_out, exp_v)
			end
		end
		rd_seen <= rd_in;
	end

	// watchdog, well beyond one balancing timer tick
	initial begin
		repeat (60000) @(posedge clk_in);
		mismatches++;
		$display("ERROR %0t: run timed out", $time);
		wrap_up();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		do_reset();
		// reset values, and an unmapped address reads zero
		rd(8'h05, 16'h1388);
		rd(8'h06, 16'hF830);
		rd(8'h07, 16'hF830);
		rd(8'h0D, 16'h0000);
		rd(8'h40, 16'h0000);
		// every sink select code: sinks only on the all-ones code
		for (int c = 0; c < 4; c++) begin
			wr(8'h02, 16'(c));
			@(negedge clk_in);
			`CHK(sink_pos_out, 1'(c == 3))
			`CHK(sink_neg_out, 1'(c == 3))
		end
		// clamp at both ends, lowest channel has no negative range
		conv(4'h0, 16'hFE0C, 16'hFE0C);
		rd(8'h20, 16'h0000);
		conv(4'h5, 16'hF63C, 16'hF63C);
		rd(8'h25, 16'hF830);
		conv(4'h5, 16'h1770, 16'h1770);
		rd(8'h25, 16'h1388);
		// random in-range values land in each of channels 1 to 15's own result
		for (int ch = 1; ch < 16; ch++) begin
			seed = xs(seed);
			v = 16'hF830 + 16'(seed % 32'h0000_1B59);
			conv(4'(ch), v, v);
			rd(8'h20 + 8'(ch), v);
		end
		// over/under detection skips flagged channels; ch2 low reg, ch10 high reg
		do_reset();
		wr(8'h00, 16'h0004);
		wr(8'h01, 16'h0004);
		wr(8'h05, 16'h0BB8);
		wr(8'h06, 16'hFC18);
		wr(8'h04, 16'h0001);
		conv(4'h2, 16'h0FA0, 16'h0FA0);
		conv(4'h4, 16'h0FA0, 16'h0FA0);
		conv(4'h8, 16'h0FA0, 16'h0FA0);
		conv(4'hA, 16'hFA24, 16'hFA24);
		conv(4'h6, 16'hFA24, 16'hFA24);
		rd(8'h0E, 16'h0110);
		rd(8'h0F, 16'h0040);
		rd(8'h0B, 16'h0003);
		// interrupt: masked, unmasked, cleared by writing one
		@(negedge clk_in);
		`CHK(irq_out, 1'b0)
		wr(8'h0C, 16'h0001);
		@(negedge clk_in);
		`CHK(irq_out, 1'b1)
		wr(8'h0B, 16'h0001);
		rd(8'h0B, 16'h0002);
		@(negedge clk_in);
		`CHK(irq_out, 1'b0)
		// dedicated pair: main against aux within tolerance, then outside
		do_reset();
		wr(8'h0A, 16'h0019);
		wr(8'h04, 16'h0008);
		bbconv(16'h0064, 16'h0069);
		rd(8'h11, 16'h0064);
		rd(8'h0B, 16'h0000);
		bbconv(16'h0064, 16'h00C8);
		rd(8'h0B, 16'h0008);
		// shared channel: sense channel main against aux plus bar value
		do_reset();
		wr(8'h0A, 16'h0019);
		wr(8'h03, 16'h0006);
		wr(8'h04, 16'h0008);
		bbconv(16'h001E, 16'h001E);
		conv(4'h6, 16'h0BD6, 16'h0BB8);
		rd(8'h0B, 16'h0000);
		// bar on ch3: compared as the summed pair, not channel alone
		wr(8'h00, 16'h0008);
		conv(4'h4, 16'h0BB8, 16'h0BA4);
		conv(4'h3, 16'h0032, 16'h005A);
		rd(8'h0B, 16'h0000);
		conv(4'h3, 16'h0032, 16'h00C8);
		rd(8'h0B, 16'h0004);
		rd(8'h10, 16'h0008);
		// balancing: bar ch3 and cell above ch4, one tick timer
		do_reset();
		wr(8'h00, 16'h0008);
		wr(8'h07, 16'h0BB8);
		wr(8'h09, 16'h0001);
		wr(8'h08, 16'h0018);
		wr(8'h04, 16'h0006);
		repeat (3) @(posedge clk_in);
		rd(8'h0D, 16'h0018);
		rd(8'h0B, 16'h0000);
		conv(4'h4, 16'h0B54, 16'h0B54);
		conv(4'h3, 16'h0064, 16'h0064);
		rd(8'h0D, 16'h0008);
		@(negedge clk_in);
		`CHK(balancing_switch_out, 16'h0008)
		// bar switch stays on until its timer runs out
		repeat (39000) @(negedge clk_in);
		`CHK(balancing_switch_out, 16'h0008)
		`CHK(balancing_complete_flag_out, 1'b0)
		repeat (1100) @(negedge clk_in);
		`CHK(balancing_switch_out, 16'h0000)
		`CHK(balancing_complete_flag_out, 1'b1)
		rd(8'h0B, 16'h0010);
		repeat (3) @(posedge clk_in);
		wrap_up();
	end
endmodule : test_bbch_top
